// File: rtl/ddt_pkg.sv
// Shared constants, command codes and timing counts of the DDR3 timing link.
// Assumes a 40 MHz system clock; the link clock is divided down from it.
package ddt_pkg;
   // ----------------------------------------------------------------
   // Clocking
   // ----------------------------------------------------------------
   localparam int CLK_PS  = 25000;
   localparam int CK_HALF = 2;
   localparam int TCK_PS  = CLK_PS * 2 * CK_HALF;
   localparam int CW      = 10;

   function automatic int cyc(input int ps, input int min_ck);
      int n;
      n = (ps + TCK_PS - 1) / TCK_PS;
      return (n > min_ck) ? n : min_ck;
   endfunction : cyc

   // ----------------------------------------------------------------
   // Times in picoseconds, as printed
   // ----------------------------------------------------------------
   localparam int T_MOD_PS  = 15000;
   localparam int T_RTP_PS  = 7500;
   localparam int T_WTR_PS  = 7500;
   localparam int T_WR_PS   = 15000;
   localparam int T_RP_PS   = 13090;
   localparam int T_RRD_PS  = 6000;
   localparam int T_FAW_PS  = 35000;
   localparam int T_RFC_PS  = 110000;
   localparam int T_XADD_PS = 10000;
   localparam int T_CKE_PS  = 5000;

   // ----------------------------------------------------------------
   // Counts in link clock cycles
   // ----------------------------------------------------------------
   localparam int N_MRD    = 4;
   localparam int N_MOD    = cyc(T_MOD_PS, 12);
   localparam int N_CCD    = 4;
   localparam int N_RTP    = cyc(T_RTP_PS, 4);
   localparam int N_WTR    = cyc(T_WTR_PS, 4);
   localparam int N_RP     = cyc(T_RP_PS, 1);
   localparam int N_DAL    = cyc(T_WR_PS, 1) + N_RP;
   localparam int N_MPRR   = 1;
   localparam int N_RRD    = cyc(T_RRD_PS, 4);
   localparam int N_FAW    = cyc(T_FAW_PS, 1);
   localparam int N_ZQINIT = 512;
   localparam int N_ZQOPER = 256;
   localparam int N_ZQCS   = 64;
   localparam int N_XS     = cyc(T_RFC_PS + T_XADD_PS, 5);
   localparam int N_DLLK   = 512;
   localparam int N_CKESR  = cyc(T_CKE_PS, 3) + 1;
   localparam int RL       = 6;
   localparam int CWL      = 5;
   localparam int BL       = 8;
   localparam int N_RDBUSY = RL + BL / 2 + 1;
   localparam int N_WRDONE = CWL + BL / 2;

   typedef enum logic [3:0] {
      DDT_NOP   = 4'h0,
      DDT_MRS   = 4'h1,
      DDT_ACT   = 4'h2,
      DDT_RD    = 4'h3,
      DDT_WR    = 4'h4,
      DDT_WRA   = 4'h5,
      DDT_PRE   = 4'h6,
      DDT_REF   = 4'h7,
      DDT_ZQCL  = 4'h8,
      DDT_ZQCS  = 4'h9,
      DDT_SRE   = 4'ha,
      DDT_SRX   = 4'hb,
      DDT_MPRRD = 4'hc
   } ddt_cmd_t;
endpackage : ddt_pkg

// File: rtl/ddt_link_if.sv
// Link between the memory controller end and the memory device end.
// The strobe wire reads low while nobody drives it.
`timescale 1ns/1ps
interface ddt_link_if;
   import ddt_pkg::*;
   logic        ck;
   logic        cke;
   ddt_cmd_t    cmd;
   logic [2:0]  bank;
   logic        dqs_o;
   logic        dqs_oe_n;
   logic [15:0] dq_o;
   wire         dqs = dqs_oe_n ? 1'b0 : dqs_o;
   wire  [15:0] dq  = dqs_oe_n ? 16'h0000 : dq_o;

   modport ctl (output ck, cke, cmd, bank, input dqs, dq);
   modport mem (input ck, cke, cmd, bank, output dqs_o, dqs_oe_n, dq_o);
endinterface : ddt_link_if

// File: rtl/ddt_mem.sv
// Memory device end: calibration and DLL timers, read strobe window.
// Samples the link clock and command pins through two flip-flops.
`timescale 1ns/1ps
module ddt_mem
   import ddt_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   ddt_link_if.mem          lnk,
   input  wire logic [15:0] fill_data,
   output logic             cmd_seen,
   output ddt_cmd_t         cmd_code,
   output logic             cal_busy,
   output logic             dll_locked,
   output logic             in_sref
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] ck_s_ff, cke_s_ff;
   logic [3:0] cmd_s1_ff, cmd_s2_ff;
   logic       ck_d_ff;
   logic       ck_rise, ck_fall;
   ddt_cmd_t   cmd_now;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ck_s_ff   <= 2'h0;
         cke_s_ff  <= 2'h0;
         cmd_s1_ff <= 4'h0;
         cmd_s2_ff <= 4'h0;
         ck_d_ff   <= 1'b0;
      end else begin
         ck_s_ff   <= {ck_s_ff[0], lnk.ck};
         cke_s_ff  <= {cke_s_ff[0], lnk.cke};
         cmd_s1_ff <= lnk.cmd;
         cmd_s2_ff <= cmd_s1_ff;
         ck_d_ff   <= ck_s_ff[1];
      end
   end

   assign ck_rise = ck_s_ff[1] & ~ck_d_ff;
   assign ck_fall = ~ck_s_ff[1] & ck_d_ff;
   assign cmd_now = ddt_cmd_t'(cmd_s2_ff);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_seen <= 1'b0;
         cmd_code <= DDT_NOP;
      end else begin
         cmd_seen <= ck_rise & (cmd_now != DDT_NOP);
         if (ck_rise) begin
            cmd_code <= cmd_now;
         end
      end
   end

   // ----------------------------------------------------------------
   // Calibration and DLL relock timers
   // ----------------------------------------------------------------
   logic [CW-1:0] cal_ff, dll_ff;
   logic          init_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cal_ff   <= '0;
         init_ff  <= 1'b0;
         cal_busy <= 1'b0;
      end else if (ck_rise) begin
         if (!init_ff && cke_s_ff[1]) begin
            init_ff <= 1'b1;
            cal_ff  <= CW'(N_ZQINIT - 1);
         end else if (cmd_now == DDT_ZQCL) begin
            cal_ff  <= CW'(N_ZQOPER - 1);
         end else if (cmd_now == DDT_ZQCS) begin
            cal_ff  <= CW'(N_ZQCS - 1);
         end else if (cal_ff != '0) begin
            cal_ff  <= cal_ff - 1'b1;
         end
         cal_busy <= (!init_ff && cke_s_ff[1]) || cmd_now == DDT_ZQCL
                     || cmd_now == DDT_ZQCS || cal_ff > CW'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dll_ff     <= '0;
         dll_locked <= 1'b1;
         in_sref    <= 1'b0;
      end else if (ck_rise) begin
         if (cmd_now == DDT_SRE) begin
            in_sref <= 1'b1;
         end else if (cmd_now == DDT_SRX) begin
            in_sref <= 1'b0;
         end
         if (cmd_now == DDT_SRX) begin
            dll_ff     <= CW'(N_DLLK - 1);
            dll_locked <= 1'b0;
         end else begin
            if (dll_ff != '0) begin
               dll_ff <= dll_ff - 1'b1;
            end
            dll_locked <= (dll_ff <= CW'(1)) && !in_sref;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read strobe and data
   // ----------------------------------------------------------------
   // One read in flight; the controller keeps reads N_RDBUSY link cycles apart.
   localparam logic [4:0] RL_M1  = 5'(RL - 1);
   localparam logic [4:0] RL_C   = 5'(RL);
   localparam logic [4:0] RL_END = 5'(RL + BL / 2);

   logic [4:0]  rd_cnt_ff;
   logic        rd_act_ff;
   logic [15:0] beat_ff;
   logic        in_burst;

   // The falling edge sees the count already stepped by the rising edge
   assign in_burst = rd_act_ff && rd_cnt_ff > RL_C && rd_cnt_ff <= RL_END;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_act_ff    <= 1'b0;
         rd_cnt_ff    <= 5'h00;
         lnk.dqs_o    <= 1'b0;
         lnk.dqs_oe_n <= 1'b1;
         lnk.dq_o     <= 16'h0000;
         beat_ff      <= 16'h0000;
      end else if (ck_rise) begin
         if (cmd_now == DDT_RD || cmd_now == DDT_MPRRD) begin
            rd_act_ff <= 1'b1;
            rd_cnt_ff <= 5'h01;
            beat_ff   <= fill_data;
         end else if (rd_act_ff) begin
            rd_cnt_ff <= rd_cnt_ff + 5'h01;
            if (rd_cnt_ff == RL_M1) begin
               lnk.dqs_oe_n <= 1'b0;
               lnk.dqs_o    <= 1'b0;
            end else if (rd_cnt_ff >= RL_C && rd_cnt_ff < RL_END) begin
               lnk.dqs_o <= 1'b1;
               lnk.dq_o  <= beat_ff;
               beat_ff   <= beat_ff + 16'h0001;
            end else if (rd_cnt_ff == RL_END) begin
               lnk.dqs_oe_n <= 1'b1;
               lnk.dqs_o    <= 1'b0;
               rd_act_ff    <= 1'b0;
            end
         end
      end else if (ck_fall && in_burst) begin
         lnk.dqs_o <= 1'b0;
         lnk.dq_o  <= beat_ff;
         beat_ff   <= beat_ff + 16'h0001;
      end
   end
endmodule : ddt_mem

// File: rtl/ddt_ctl.sv
// Memory controller end: makes the link clock, spaces commands.
// Assumes a requester that holds req_valid until req_ack pulses.
`timescale 1ns/1ps
module ddt_ctl
   import ddt_pkg::*;
#(
   parameter int NBANK = 8
)(
   input  wire logic        clk,
   input  wire logic        rst_n,
   ddt_link_if.ctl          lnk,
   input  wire logic        req_valid,
   input  wire ddt_cmd_t    req_cmd,
   input  wire logic [2:0]  req_bank,
   output logic             req_ack,
   output logic [15:0]      rd_data,
   output logic             rd_valid
);
   initial begin
      if (NBANK < 1 || NBANK > 8 || CK_HALF < 2) begin
         $error("ddt_ctl: unsupported bank count or clock divider");
      end
   end

   // ----------------------------------------------------------------
   // Link clock divider
   // ----------------------------------------------------------------
   logic [3:0] div_ff;
   logic       tick;

   assign tick = lnk.ck && div_ff == 4'(CK_HALF - 1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_ff <= 4'h0;
         lnk.ck <= 1'b0;
      end else if (div_ff == 4'(CK_HALF - 1)) begin
         div_ff <= 4'h0;
         lnk.ck <= ~lnk.ck;
      end else begin
         div_ff <= div_ff + 4'h1;
      end
   end

   // ----------------------------------------------------------------
   // Spacing counters, stepped per link cycle; all_ff serves several constraints
   // ----------------------------------------------------------------
   // A counter loaded with N-1 lets the next command pass N cycles on.
   // Counts are rounded up to whole link cycles in the package
   function automatic logic [CW-1:0] ld(input int n);
      return CW'(n - 1);
   endfunction : ld

   function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
      return (v == '0) ? v : v - 1'b1;
   endfunction : dec

   typedef enum logic [1:0] {
      CS_RESET = 2'b00,
      CS_IDLE  = 2'b01,
      CS_SREF  = 2'b10
   } ddt_cstate_t;

   ddt_cstate_t   st_ff;
   logic [CW-1:0] all_ff, mrd_ff, mod_ff, ccd_ff, wtr_ff, rrd_ff;
   logic [CW-1:0] dll_ff, sr_ff, rdb_ff;
   logic [CW-1:0] pre_ff [NBANK];
   logic [CW-1:0] act_ff [NBANK];
   logic [CW-1:0] faw_ff [4];
   logic          take;
   logic          ok;
   logic          faw_free;
   logic [1:0]    faw_slot;
   ddt_cmd_t      c;

   assign c    = req_cmd;
   assign take = tick && st_ff != CS_RESET && req_valid && ok;

   always_comb begin
      faw_free = 1'b0;
      faw_slot = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (faw_ff[i] == '0) begin
            faw_free = 1'b1;
            faw_slot = 2'(i);
         end
      end
   end

   always_comb begin
      ok = (all_ff == '0);
      if (st_ff == CS_SREF) begin
         ok = ok && c == DDT_SRX && sr_ff == '0;
      end else if (c == DDT_SRX || c == DDT_NOP) begin
         ok = 1'b0;
      end
      if (c == DDT_MRS) begin
         ok = ok && mrd_ff == '0;
      end else begin
         ok = ok && mod_ff == '0;
      end
      if (c == DDT_RD || c == DDT_WR || c == DDT_WRA || c == DDT_MPRRD) begin
         ok = ok && ccd_ff == '0 && dll_ff == '0 && rdb_ff == '0;
      end
      if (c == DDT_RD || c == DDT_MPRRD) begin
         ok = ok && wtr_ff == '0;
      end
      if (c == DDT_PRE) begin
         ok = ok && pre_ff[req_bank] == '0;
      end
      if (c == DDT_ACT) begin
         ok = ok && act_ff[req_bank] == '0 && rrd_ff == '0
              && faw_free;
      end
   end

   // ----------------------------------------------------------------
   // Controller state and clock enable
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff   <= CS_RESET;
         lnk.cke <= 1'b0;
         sr_ff   <= '0;
      end else if (tick) begin
         sr_ff <= dec(sr_ff);
         unique case (st_ff)
            CS_RESET: begin
               st_ff   <= CS_IDLE;
               lnk.cke <= 1'b1;
            end
            CS_IDLE: begin
               if (take && c == DDT_SRE) begin
                  st_ff   <= CS_SREF;
                  lnk.cke <= 1'b0;
                  sr_ff   <= ld(N_CKESR);
               end
            end
            CS_SREF: begin
               if (take) begin
                  st_ff   <= CS_IDLE;
                  lnk.cke <= 1'b1;
               end
            end
            default: begin
               st_ff <= CS_RESET;
            end
         endcase
      end
   end

   // Blocks every command: reset exit, calibration, readout, exit.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         all_ff <= '0;
      end else if (tick) begin
         if (st_ff == CS_RESET) begin
            all_ff <= ld(N_ZQINIT > N_XS ? N_ZQINIT : N_XS);
         end else if (take && c == DDT_ZQCL) begin
            all_ff <= ld(N_ZQOPER);
         end else if (take && c == DDT_ZQCS) begin
            all_ff <= ld(N_ZQCS);
         end else if (take && c == DDT_SRX) begin
            all_ff <= ld(N_XS);
         end else if (take && c == DDT_MPRRD) begin
            all_ff <= ld(N_MPRR);
         end else begin
            all_ff <= dec(all_ff);
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mrd_ff <= '0;
         mod_ff <= '0;
         ccd_ff <= '0;
         wtr_ff <= '0;
         rrd_ff <= '0;
         dll_ff <= '0;
         rdb_ff <= '0;
      end else if (tick) begin
         mrd_ff <= (take && c == DDT_MRS) ? ld(N_MRD) : dec(mrd_ff);
         mod_ff <= (take && c == DDT_MRS) ? ld(N_MOD) : dec(mod_ff);
         ccd_ff <= (take && (c == DDT_RD || c == DDT_WR || c == DDT_WRA
                   || c == DDT_MPRRD)) ? ld(N_CCD) : dec(ccd_ff);
         wtr_ff <= (take && (c == DDT_WR || c == DDT_WRA))
                   ? ld(N_WRDONE + N_WTR) : dec(wtr_ff);
         rrd_ff <= (take && c == DDT_ACT) ? ld(N_RRD) : dec(rrd_ff);
         dll_ff <= (take && c == DDT_SRX) ? ld(N_DLLK) : dec(dll_ff);
         rdb_ff <= (take && (c == DDT_RD || c == DDT_MPRRD))
                   ? ld(N_RDBUSY) : dec(rdb_ff);
      end
   end

   for (genvar i = 0; i < 4; i++) begin : g_faw
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            faw_ff[i] <= '0;
         end else if (tick) begin
            faw_ff[i] <= (take && c == DDT_ACT && faw_slot == 2'(i))
                         ? ld(N_FAW) : dec(faw_ff[i]);
         end
      end
   end

   for (genvar b = 0; b < NBANK; b++) begin : g_bank
      logic hit;
      assign hit = take && req_bank == 3'(b);
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            pre_ff[b] <= '0;
            act_ff[b] <= '0;
         end else if (tick) begin
            pre_ff[b] <= (hit && c == DDT_RD) ? ld(N_RTP)
                         : dec(pre_ff[b]);
            if (hit && c == DDT_WRA) begin
               act_ff[b] <= ld(N_WRDONE + N_DAL);
            end else if (hit && c == DDT_PRE) begin
               act_ff[b] <= ld(N_RP);
            end else begin
               act_ff[b] <= dec(act_ff[b]);
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Command pins, set on the link clock falling edge
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lnk.cmd  <= DDT_NOP;
         lnk.bank <= 3'h0;
         req_ack  <= 1'b0;
      end else begin
         req_ack <= take;
         if (tick) begin
            lnk.cmd  <= take ? c : DDT_NOP;
            lnk.bank <= take ? req_bank : lnk.bank;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read capture on every strobe edge
   // ----------------------------------------------------------------
   logic [1:0]  dqs_s_ff;
   logic        dqs_d_ff;
   logic [15:0] dq_s1_ff, dq_s2_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dqs_s_ff <= 2'h0;
         dqs_d_ff <= 1'b0;
         dq_s1_ff <= 16'h0000;
         dq_s2_ff <= 16'h0000;
         rd_data  <= 16'h0000;
         rd_valid <= 1'b0;
      end else begin
         dqs_s_ff <= {dqs_s_ff[0], lnk.dqs};
         dqs_d_ff <= dqs_s_ff[1];
         dq_s1_ff <= lnk.dq;
         dq_s2_ff <= dq_s1_ff;
         rd_valid <= dqs_s_ff[1] ^ dqs_d_ff;
         if (dqs_s_ff[1] ^ dqs_d_ff) begin
            rd_data <= dq_s2_ff;
         end
      end
   end
endmodule : ddt_ctl

// File: sim/ddt_chk.sv
// Checker for the DDR3 timing link: command spacing and strobe window.
// Assumes the link signals of ddt_link_if, sampled by the system clock.
`timescale 1ns/1ps
module ddt_chk
   import ddt_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       ck,
   input wire logic       cke,
   input wire ddt_cmd_t   cmd,
   input wire logic [2:0] bank,
   input wire logic       dqs_oe_n
);
   // ------------------------------------------------------------
   // Link cycle stamps
   // ------------------------------------------------------------
   // Stamps start at zero; the long start-up wait keeps them harmless
   logic        ck_q_ff;
   logic        up_ff;
   logic        rise;
   logic        col;
   logic [15:0] lc_ff, now, mrs_ff, col_ff, act_ff, wr_ff, rd_ff;
   logic [15:0] wra_ff, zl_ff, zs_ff, srx_ff, sre_ff, cke_ff;
   logic [2:0]  rdb_ff, wrab_ff;

   assign rise = ck & ~ck_q_ff;
   assign now  = lc_ff + 16'h1;
   assign col  = cmd inside {DDT_RD, DDT_WR, DDT_WRA};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ck_q_ff <= 1'b0;
         lc_ff   <= 16'h0;
      end else begin
         ck_q_ff <= ck;
         if (rise) lc_ff <= now;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {mrs_ff, col_ff, act_ff, wr_ff, rd_ff, wra_ff} <= '0;
         {zl_ff, zs_ff, srx_ff, sre_ff, cke_ff, rdb_ff, wrab_ff} <= '0;
         up_ff <= 1'b0;
      end else if (rise) begin
         if (!cke && !up_ff) cke_ff <= now;
         if (cke && cmd != DDT_NOP) up_ff <= 1'b1;
         if (cmd == DDT_MRS) mrs_ff <= now;
         if (col) col_ff <= now;
         if (cmd == DDT_ACT) act_ff <= now;
         if (cmd inside {DDT_WR, DDT_WRA}) wr_ff <= now;
         if (cmd inside {DDT_RD, DDT_MPRRD}) rd_ff <= now;
         if (cmd inside {DDT_RD, DDT_MPRRD}) rdb_ff <= bank;
         if (cmd == DDT_WRA) wra_ff <= now;
         if (cmd == DDT_WRA) wrab_ff <= bank;
         if (cmd == DDT_ZQCL) zl_ff <= now;
         if (cmd == DDT_ZQCS) zs_ff <= now;
         if (cmd == DDT_SRX) srx_ff <= now;
         if (cmd == DDT_SRE) sre_ff <= now;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   AST_MRD: assert property (rise && cmd == DDT_MRS |-> now - mrs_ff >= 4)
      else $error("mode sets too close");
   AST_MOD: assert property (rise && !(cmd inside {DDT_NOP, DDT_MRS})
      |-> now - mrs_ff >= N_MOD) else $error("mode update wait short");
   AST_CCD: assert property (rise && col |-> now - col_ff >= N_CCD)
      else $error("column commands too close");
   AST_RTP: assert property (rise && cmd == DDT_PRE && bank == rdb_ff
      |-> now - rd_ff >= N_RTP) else $error("read to precharge short");
   AST_WTR: assert property (rise && cmd == DDT_RD
      |-> now - wr_ff >= N_WRDONE + N_WTR) else $error("write to read short");
   AST_DAL: assert property (rise && cmd == DDT_ACT && bank == wrab_ff
      |-> now - wra_ff >= N_WRDONE + N_DAL) else $error("auto precharge short");
   AST_RRD: assert property (rise && cmd == DDT_ACT
      |-> now - act_ff >= N_RRD) else $error("activates too close");
   AST_ZQINIT: assert property (rise && cmd != DDT_NOP && !up_ff
      |-> now - cke_ff >= N_ZQINIT) else $error("start-up wait short");
   AST_ZQOPER: assert property (rise && cmd != DDT_NOP
      |-> now - zl_ff >= N_ZQOPER) else $error("full calibration cut");
   AST_ZQCS: assert property (rise && cmd != DDT_NOP
      |-> now - zs_ff >= N_ZQCS) else $error("short calibration cut");
   AST_XS: assert property (rise && cmd != DDT_NOP
      |-> now - srx_ff >= N_XS) else $error("self refresh exit short");
   AST_XSDLL: assert property (rise && col
      |-> now - srx_ff >= N_DLLK) else $error("relock wait short");
   AST_CKESR: assert property (rise && cmd == DDT_SRX
      |-> now - sre_ff >= N_CKESR) else $error("self refresh too short");
   AST_PRE: assert property ($fell(dqs_oe_n)
      |-> lc_ff - rd_ff == RL - 1) else $error("strobe drive early or late");
   AST_PST: assert property ($rose(dqs_oe_n)
      |-> lc_ff - rd_ff == RL + BL / 2) else $error("strobe release wrong");

   cover property (rise && cmd == DDT_SRX);
   cover property (rise && cmd == DDT_ZQCL);
   cover property ($rose(dqs_oe_n));
endmodule : ddt_chk

// File: sim/tb.sv
// Testbench: controller and memory ends joined by one link.
// Assumes the counts of ddt_pkg and a 40 MHz system clock.
`timescale 1ns/1ps
module tb;
   import ddt_pkg::*;
   logic        clk;
   logic        rst_n;
   logic        req_valid, req_ack, rd_valid, cmd_seen;
   logic        cal_busy, dll_locked, in_sref;
   ddt_cmd_t    req_cmd, cmd_code;
   logic [2:0]  req_bank;
   logic [15:0] fill_data, rd_data;
   int          n_fail, cmp_count, t_ack, t_srx, n0;
   int          cyc = 0;

   ddt_link_if lnk_if ();
   ddt_ctl u_ddt_ctl (.clk(clk), .rst_n(rst_n), .lnk(lnk_if),
      .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank),
      .req_ack(req_ack), .rd_data(rd_data), .rd_valid(rd_valid));
   ddt_mem u_ddt_mem (.clk(clk), .rst_n(rst_n), .lnk(lnk_if),
      .fill_data(fill_data), .cmd_seen(cmd_seen), .cmd_code(cmd_code),
      .cal_busy(cal_busy), .dll_locked(dll_locked), .in_sref(in_sref));
   ddt_chk u_ddt_chk (.clk(clk), .rst_n(rst_n), .ck(lnk_if.ck),
      .cke(lnk_if.cke), .cmd(lnk_if.cmd), .bank(lnk_if.bank),
      .dqs_oe_n(lnk_if.dqs_oe_n));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) cyc <= cyc + 1;

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic test_done;
      $display("compares %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp,
                      input bit at_least);
      cmp_count++;
      if (at_least ? (got >= exp) !== 1'b1 : got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   // Gap is in link cycles from the previous accepted request
   task automatic go(input ddt_cmd_t c, input logic [2:0] b, input int gap);
      int n;
      n = 0;
      req_cmd   <= c;
      req_bank  <= b;
      req_valid <= 1'b1;
      do @(posedge clk); while (req_ack !== 1'b1 && ++n < 9000);
      req_valid <= 1'b0;
      cmp(req_ack, 1, 0);
      cmp(cyc - t_ack, gap * 4, 1);
      t_ack = cyc;
      n = 0;
      do @(posedge clk); while (cmd_seen !== 1'b1 && ++n < 12);
      cmp(cmd_code, c, 0);
   endtask : go

   task automatic beats(input logic [15:0] f);
      int n;
      cmp(lnk_if.dqs_oe_n, 1, 0);
      for (int i = 0; i < BL; i++) begin
         n = 0;
         do @(posedge clk); while (rd_valid !== 1'b1 && ++n < 100);
         cmp(rd_data, 16'(f + i), 0);
      end
   endtask : beats

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_init;
      go(DDT_MRS, 3'h0, N_ZQINIT);
      go(DDT_MRS, 3'h1, N_MRD);
      go(DDT_ACT, 3'h0, N_MOD);
   endtask : t_init

   task automatic t_act;
      for (int i = 1; i < 5; i++) begin
         go(DDT_ACT, 3'(i), N_RRD);
      end
   endtask : t_act

   task automatic t_rw;
      go(DDT_RD, 3'h0, 0);
      beats(16'h5a30);
      go(DDT_PRE, 3'h0, N_RTP);
      go(DDT_WR, 3'h2, 0);
      fill_data <= 16'hfffc;
      go(DDT_RD, 3'h2, N_WRDONE + N_WTR);
      beats(16'hfffc);
      go(DDT_WRA, 3'h1, N_CCD);
      go(DDT_ACT, 3'h1, N_WRDONE + N_DAL);
   endtask : t_rw

   task automatic t_zq;
      go(DDT_MPRRD, 3'h0, 0);
      go(DDT_PRE, 3'h2, N_MPRR);
      go(DDT_ZQCS, 3'h0, 0);
      go(DDT_PRE, 3'h3, N_ZQCS);
      go(DDT_ZQCL, 3'h0, 0);
      cmp(cal_busy, 1, 0);
      go(DDT_PRE, 3'h4, N_ZQOPER);
   endtask : t_zq

   task automatic t_sref;
      int n;
      n = 0;
      go(DDT_SRE, 3'h0, 0);
      do @(posedge clk); while (in_sref !== 1'b1 && ++n < 16);
      cmp(in_sref, 1, 0);
      go(DDT_SRX, 3'h0, N_CKESR);
      t_srx = t_ack;
      go(DDT_ACT, 3'h5, N_XS);
      cmp(dll_locked, 0, 0);
      go(DDT_RD, 3'h5, 0);
      cmp(t_ack - t_srx, N_DLLK * 4, 1);
      cmp(dll_locked, 1, 0);
      beats(16'hfffc);
   endtask : t_sref

   initial begin
      rst_n     = 1'b0;
      req_valid = 1'b0;
      req_cmd   = DDT_NOP;
      req_bank  = 3'h0;
      fill_data = 16'h5a30;
      n_fail    = 0;
      cmp_count = 0;
      n0        = 0;
      repeat (16) @(posedge clk);
      cmp(dll_locked, 1, 0);
      rst_n <= 1'b1;
      do @(posedge clk); while (lnk_if.cke !== 1'b1 && ++n0 < 16);
      t_ack = cyc;
      t_init();
      t_act();
      t_rw();
      t_zq();
      t_sref();
      test_done();
   end

   // Whole run is near 6000 cycles; allow ample margin
   initial begin
      #(25 * 40000);
      n_fail++;
      test_done();
   end
endmodule : tb
